// ---- usb_sys_params.svh ----
/*
 * Constants of the USB system block: word indices, fields, resets and counts.
 * Assumes inclusion by bare name.
 */
`ifndef USB_SYS_PARAMS_SVH
`define USB_SYS_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define SCR_IDX          14'h1C32
`define ATTACH_IDX       14'h0000
`define INDEX_IDX        14'h0001
`define TXCFG_IDX        14'h0002
`define RXCFG_IDX        14'h0003
`define STATUS_IDX       14'h0004
`define CAUSE_IDX        14'h0005
`define RAMPTR_IDX       14'h0006
`define RAMDATA_IDX      14'h0007

// System control register layout.
`define SCR_RESET        16'hA000
`define SCR_WR_MASK      16'hF04F

// Lane masks for the byte-lane select field.
`define LANE_WORD        2'h0
`define LANE_HIGH        2'h1
`define LANE_LOW         2'h2
`define MASK_ALL         16'hFFFF
`define MASK_HIGH        16'hFF00
`define MASK_LOW         16'h00FF
`define MASK_NONE        16'h0000

// FIFO RAM: 4K bytes held as 16-bit words.
`define RAM_WORDS        2048
`define RAM_PTR_W        11
`define EP0_START        12'h000
`define EP0_MAXPKT       11'h040
`define EP_LAST          3'h4

// Attach register fields.
`define ATT_SOFT_BIT     0
`define ATT_DATA_BIT     1
`define ATT_HS_BIT       2

// Bus reset is SE0 held this many 8 ns cycles, 2.5 us rounded up.
`define BUS_RESET_CYC    313
`define RST_CNT_W        9

`endif

// ---- usb_sys_pkg.sv ----
/*
 * Types of the USB system block: register layout, FIFO settings, events, lines, states.
 * Assumes nothing of its surroundings.
 */
package usb_sys_pkg;

   typedef struct packed {
      logic       module_power_down;
      logic       session_end_comparator_enable;
      logic       vbus_detect_enable;
      logic       pll_suspend_override;
      logic [4:0] rsvd_hi;
      logic       data_line_polarity;
      logic [1:0] rsvd_lo;
      logic       osc_bias_disable;
      logic       osc_disable;
      logic [1:0] byte_lane_select;
   } sys_ctrl_t;

   typedef struct packed {
      logic        double_buf;
      logic [10:0] max_pkt;
      logic [11:0] start_addr;
   } ep_fifo_cfg_t;

   typedef struct packed {
      logic [4:0] tx_done;
      logic [3:0] rx_done;
      logic       suspend;
      logic       resume;
      logic       sof;
   } usb_evt_t;

   typedef struct packed {
      logic dp;
      logic dm;
      logic oe;
   } usb_line_t;

   typedef enum logic [1:0] {
      ST_DETACHED,
      ST_FS_ATTACH,
      ST_ACTIVE
   } session_state_t;

endpackage

// ---- usb_sys_config_fifo_alloc.sv ----
/*
 * Control register, FIFO allocation in a shared 4K RAM, session entry, bus reset
 * detection and interrupt causes of a USB peripheral controller.
 * Assumes a Wishbone master and USB engine on clk_i, and asynchronous pins.
 */
// The Wishbone register port is this design's own decision.
// Operation
// [RULE1] Bit 15 powers module down, resets one
// [RULE2] Bit 14 enables session-end comparator
// [RULE3] Bit 13 enables VBUS detect, resets one
// [RULE4] Bit 12 forces PLL out of suspend
// [RULE5] Bits 11-7 read zero; software writes zero
// [RULE6] Bit 6 set means normal line polarity
// [RULE7] Bit 3 disables oscillator bias resistor
// [RULE8] Bit 2 disables the internal oscillator
// [RULE9] Bits 1-0 select word or byte lane
// [RULE10] One shared 4K FIFO RAM for endpoints
// [RULE11] Per-endpoint start, max packet, double buffer
// [RULE12] Endpoint zero fixed: 64 bytes at zero
// [RULE13] Firmware gives endpoints exclusive sufficient RAM
// [RULE14] Session needs VBUS, attach and data lines
// [RULE15] Session first attaches as full speed
// [RULE16] Full-speed attach waits for host bus reset
// [RULE17] Interrupt on transfers and bus events
// [RULE18] CPU reads cause register, then dispatches
// [RULE19] Software services endpoint zero first, suspend last
// [RULE20] Runs as high-speed or full-speed peripheral
// [RULE21] Software attach resets zero, appears disconnected
// [RULE22] Byte-lane mode gates CPU data transfers
`timescale 1ns/1ps
`include "usb_sys_params.svh"

module usb_sys_config_fifo_alloc
   import usb_sys_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [15:0]  wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         vbus_valid_i,
   input  wire logic         session_end_i,
   input  wire logic         dp_i,
   input  wire logic         dm_i,
   output logic              dp_o,
   output logic              dm_o,
   output logic              dp_oe_o,
   output logic              dm_oe_o,
   output logic              fs_pullup_o,
   input  wire usb_line_t    core_line_i,
   output usb_line_t         core_line_o,
   input  wire usb_evt_t     core_evt_i,
   input  wire logic         core_chirp_ok_i,
   input  wire logic [2:0]   core_ep_i,
   output ep_fifo_cfg_t      core_tx_cfg_o,
   output ep_fifo_cfg_t      core_rx_cfg_o,
   input  wire logic [10:0]  core_ram_adr_i,
   input  wire logic         core_ram_we_i,
   input  wire logic [15:0]  core_ram_dat_i,
   output logic      [15:0]  core_ram_dat_o,
   output logic              session_o,
   output logic              high_speed_o,
   output logic              bus_reset_o,
   output logic              module_power_down_o,
   output logic              session_end_comparator_enable_o,
   output logic              vbus_detect_enable_o,
   output logic              pll_suspend_override_o,
   output logic              pll_suspend_o,
   output logic              osc_bias_disable_o,
   output logic              osc_disable_o,
   output logic              irq_o
);

   sys_ctrl_t             scr_q;
   logic [2:0]            attach_q;
   logic [2:0]            index_q;
   ep_fifo_cfg_t          tx_cfg_q [1:4];
   ep_fifo_cfg_t          rx_cfg_q [1:4];
   logic [`RAM_PTR_W-1:0] ram_ptr_q;
   logic [15:0]           ram_q [0:`RAM_WORDS-1];
   logic [14:0]           cause_q;
   logic                  ack_q;
   logic [31:0]           rdat_q;
   session_state_t        state_q;
   logic                  hs_q;
   logic                  suspended_q;
   logic                  bus_reset_q;
   logic [`RST_CNT_W-1:0] se0_cnt_q;
   logic [3:0]            meta_q;
   logic [3:0]            sync_q;
   logic                  vbus_prev_q;
   usb_line_t             pin_q;
   logic                  pullup_q;

   logic        req;
   logic        wr;
   logic        rd;
   logic [13:0] idx;
   logic [15:0] lane16;
   logic [31:0] wmask;
   logic [31:0] lane32;
   logic [15:0] scr_bm;
   logic        ep_sel_ok;
   logic        vbus_ok;
   logic        sess_ok;
   logic        line_dp;
   logic        line_dm;
   logic        se0;
   logic        rst_hit;
   logic [14:0] cause_set;
   logic [31:0] rd_mux;

   // Lane mask per byte-lane mode; the reserved code moves no data except through the control register.
   function automatic logic [15:0] lane_mask(input logic [1:0] mode);
      case (mode)
         `LANE_WORD: lane_mask = `MASK_ALL;
         `LANE_HIGH: lane_mask = `MASK_HIGH;
         `LANE_LOW:  lane_mask = `MASK_LOW;
         default:    lane_mask = `MASK_NONE;
      endcase
   endfunction

   // Bus decode; the first cycle of a request is taken, ack follows one edge later.
   assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr     = req & wb_we_i;
   assign rd     = req & ~wb_we_i;
   assign idx    = wb_adr_i[15:2];
   assign lane16 = lane_mask(scr_q.byte_lane_select);                              // [RULE9]
   assign lane32 = {(scr_q.byte_lane_select == `LANE_WORD) ? `MASK_ALL : `MASK_NONE, lane16};
   assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & lane32; // [RULE22]
   assign scr_bm = `SCR_WR_MASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};           // [RULE5]
   assign ep_sel_ok = (index_q != 3'h0) && (index_q <= `EP_LAST);                  // [RULE12]

   // Session qualifiers; a powered-down module or disabled detector never sees VBUS.
   assign vbus_ok = sync_q[0] & scr_q.vbus_detect_enable & ~scr_q.module_power_down; // [RULE3]
   assign sess_ok = vbus_ok & attach_q[`ATT_SOFT_BIT] & attach_q[`ATT_DATA_BIT]
                  & ~(scr_q.session_end_comparator_enable & sync_q[1]);             // [RULE14]

   // Line view seen by the engine after the polarity swap.
   assign line_dp = scr_q.data_line_polarity ? sync_q[2] : sync_q[3];
   assign line_dm = scr_q.data_line_polarity ? sync_q[3] : sync_q[2];
   assign se0     = ~line_dp & ~line_dm;
   assign rst_hit = se0 && (se0_cnt_q == `RST_CNT_W'(`BUS_RESET_CYC - 1));

   // Pin inputs pass two flip-flops before any logic reads them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else if (ce_i) begin
         meta_q <= {dm_i, dp_i, session_end_i, vbus_valid_i};
         sync_q <= meta_q;
      end
   end

   // Control register; it ignores the lane mode, else a byte mode could lock itself in.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scr_q <= `SCR_RESET;                                                      // [RULE1]
      end else if (ce_i && wr && idx == `SCR_IDX) begin
         scr_q <= (scr_q & ~scr_bm) | (wb_dat_i[15:0] & scr_bm);                   // [RULE5]
      end
   end

   // Attach, endpoint select and RAM pointer registers, written through the lane mask.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         attach_q  <= 3'h0;                                                        // [RULE21]
         index_q   <= 3'h0;
         ram_ptr_q <= '0;
      end else if (ce_i) begin
         if (wr && idx == `ATTACH_IDX) begin
            attach_q <= (attach_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
         end
         if (wr && idx == `INDEX_IDX) begin
            index_q <= (index_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);     // [RULE11]
         end
         if (wr && idx == `RAMPTR_IDX) begin
            ram_ptr_q <= (ram_ptr_q & ~wmask[10:0]) | (wb_dat_i[10:0] & wmask[10:0]);
         end else if (req && idx == `RAMDATA_IDX) begin
            ram_ptr_q <= ram_ptr_q + `RAM_PTR_W'(1);
         end
      end
   end

   // Indexed FIFO settings for endpoints 1 to 4; endpoint 0 is fixed and not stored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 1; i <= 4; i++) begin
            tx_cfg_q[i] <= '0;
            rx_cfg_q[i] <= '0;
         end
      end else if (ce_i && wr && ep_sel_ok) begin
         if (idx == `TXCFG_IDX) begin
            tx_cfg_q[index_q] <= (tx_cfg_q[index_q] & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]); // [RULE11]
         end
         if (idx == `RXCFG_IDX) begin
            rx_cfg_q[index_q] <= (rx_cfg_q[index_q] & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]); // [RULE11]
         end
      end
   end

   // Shared FIFO RAM; the CPU writes through the lane mask, the engine writes whole words.
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (wr && idx == `RAMDATA_IDX) begin
            ram_q[ram_ptr_q] <= (ram_q[ram_ptr_q] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // [RULE10]
         end else if (core_ram_we_i) begin
            ram_q[core_ram_adr_i] <= core_ram_dat_i;                               // [RULE10]
         end
         core_ram_dat_o <= ram_q[core_ram_adr_i];
      end
   end

   // Endpoint settings handed to the engine for the endpoint it is working on.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_tx_cfg_o <= '0;
         core_rx_cfg_o <= '0;
      end else if (ce_i) begin
         if (core_ep_i == 3'h0) begin
            core_tx_cfg_o <= '{double_buf: 1'b0, max_pkt: `EP0_MAXPKT, start_addr: `EP0_START}; // [RULE12]
            core_rx_cfg_o <= '{double_buf: 1'b0, max_pkt: `EP0_MAXPKT, start_addr: `EP0_START};
         end else if (core_ep_i <= `EP_LAST) begin
            core_tx_cfg_o <= tx_cfg_q[core_ep_i];
            core_rx_cfg_o <= rx_cfg_q[core_ep_i];
         end else begin
            core_tx_cfg_o <= '0;
            core_rx_cfg_o <= '0;
         end
      end
   end

   // SE0 length counter; a line reset is only looked for while attached.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         se0_cnt_q <= '0;
      end else if (ce_i) begin
         if (!se0 || state_q == ST_DETACHED || rst_hit) begin
            se0_cnt_q <= '0;
         end else begin
            se0_cnt_q <= se0_cnt_q + `RST_CNT_W'(1);
         end
      end
   end

   // Session machine: attach at full speed, wait for host reset, then run.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= ST_DETACHED;
         hs_q        <= 1'b0;
         bus_reset_q <= 1'b0;
      end else if (ce_i) begin
         bus_reset_q <= rst_hit;
         if (!sess_ok) begin
            state_q <= ST_DETACHED;
            hs_q    <= 1'b0;
         end else begin
            case (state_q)
               ST_DETACHED: begin
                  state_q <= ST_FS_ATTACH;                                         // [RULE14]
                  hs_q    <= 1'b0;                                                 // [RULE15]
               end
               ST_FS_ATTACH: begin
                  if (rst_hit) begin
                     state_q <= ST_ACTIVE;                                         // [RULE16]
                     hs_q    <= attach_q[`ATT_HS_BIT] & core_chirp_ok_i;           // [RULE20]
                  end
               end
               ST_ACTIVE: begin
                  if (rst_hit) begin
                     hs_q <= attach_q[`ATT_HS_BIT] & core_chirp_ok_i;              // [RULE20]
                  end
               end
               default: state_q <= ST_DETACHED;
            endcase
         end
      end
   end

   // Suspend tracking for the PLL; the override keeps the PLL running regardless.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         suspended_q <= 1'b0;
         vbus_prev_q <= 1'b0;
      end else if (ce_i) begin
         vbus_prev_q <= vbus_ok;
         if (core_evt_i.resume || state_q == ST_DETACHED || rst_hit) begin
            suspended_q <= 1'b0;
         end else if (core_evt_i.suspend) begin
            suspended_q <= 1'b1;
         end
      end
   end

   // Cause register: set by events, cleared by reading it; a set in the read cycle survives.
   assign cause_set = {core_evt_i.sof, ~vbus_ok & vbus_prev_q, vbus_ok & ~vbus_prev_q, rst_hit,
                       core_evt_i.resume, core_evt_i.suspend, core_evt_i.rx_done, core_evt_i.tx_done}; // [RULE17]

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= '0;
      end else if (ce_i) begin
         cause_q <= ((rd && idx == `CAUSE_IDX) ? 15'h0000 : cause_q) | cause_set;  // [RULE18]
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      case (idx)
         `SCR_IDX:     rd_mux = {16'h0000, scr_q};                                 // [RULE5]
         `ATTACH_IDX:  rd_mux = {29'h0, attach_q};
         `INDEX_IDX:   rd_mux = {29'h0, index_q};
         `TXCFG_IDX:   rd_mux = (index_q == 3'h0) ? {8'h00, 1'b0, `EP0_MAXPKT, `EP0_START}
                              : ep_sel_ok ? {8'h00, tx_cfg_q[index_q]} : 32'h0000_0000;
         `RXCFG_IDX:   rd_mux = (index_q == 3'h0) ? {8'h00, 1'b0, `EP0_MAXPKT, `EP0_START}
                              : ep_sel_ok ? {8'h00, rx_cfg_q[index_q]} : 32'h0000_0000;
         `STATUS_IDX:  rd_mux = {26'h0, suspended_q, hs_q, state_q, vbus_ok, state_q != ST_DETACHED};
         `CAUSE_IDX:   rd_mux = {17'h0, cause_q};
         `RAMPTR_IDX:  rd_mux = {21'h0, ram_ptr_q};
         `RAMDATA_IDX: rd_mux = {16'h0000, ram_q[ram_ptr_q]};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus answer one edge after the request; byte modes hide the unselected lanes except on control register reads.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= req;
         if (rd) begin
            rdat_q <= (idx == `SCR_IDX) ? rd_mux : rd_mux & lane32;               // [RULE22]
         end
      end
   end

   // Pin drive, registered; the polarity bit swaps the pair and power-down releases it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q    <= '0;
         pullup_q <= 1'b0;
      end else if (ce_i) begin
         pin_q.dp <= scr_q.data_line_polarity ? core_line_i.dp : core_line_i.dm;   // [RULE6]
         pin_q.dm <= scr_q.data_line_polarity ? core_line_i.dm : core_line_i.dp;   // [RULE6]
         pin_q.oe <= core_line_i.oe & (state_q != ST_DETACHED);                    // [RULE21]
         pullup_q <= (state_q != ST_DETACHED) & ~hs_q;                             // [RULE15]
      end
   end

   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = rdat_q;
   assign dp_o        = pin_q.dp;
   assign dm_o        = pin_q.dm;
   assign dp_oe_o     = pin_q.oe;
   assign dm_oe_o     = pin_q.oe;
   assign fs_pullup_o = pullup_q;
   assign core_line_o = '{dp: line_dp, dm: line_dm, oe: 1'b0};
   assign session_o   = state_q != ST_DETACHED;                                    // [RULE14]
   assign high_speed_o = hs_q;
   assign bus_reset_o = bus_reset_q;
   assign irq_o       = |cause_q;                                                  // [RULE17]

   // Analog controls straight from the control register; PLL suspend also follows suspend tracking.
   assign module_power_down_o             = scr_q.module_power_down;               // [RULE1]
   assign session_end_comparator_enable_o = scr_q.session_end_comparator_enable;   // [RULE2]
   assign vbus_detect_enable_o            = scr_q.vbus_detect_enable;              // [RULE3]
   assign pll_suspend_override_o          = scr_q.pll_suspend_override;            // [RULE4]
   assign pll_suspend_o                   = suspended_q & ~scr_q.pll_suspend_override; // [RULE4]
   assign osc_bias_disable_o              = scr_q.osc_bias_disable;                // [RULE7]
   assign osc_disable_o                   = scr_q.osc_disable;                     // [RULE8]

endmodule

// ---- usb_sys_checker_assertions.sv ----
/* Port properties of the USB system block.
   Assumes binding to the top module with ce_i high. */
`timescale 1ns/1ps
module usb_sys_checker
   import usb_sys_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire usb_evt_t    core_evt_i,
   input wire logic        irq_o,
   input wire logic        session_o,
   input wire logic        fs_pullup_o,
   input wire logic        bus_reset_o,
   input wire logic        module_power_down_o,
   input wire logic        session_end_comparator_enable_o,
   input wire logic        vbus_detect_enable_o,
   input wire logic        pll_suspend_override_o,
   input wire logic        pll_suspend_o,
   input wire logic        osc_bias_disable_o,
   input wire logic        osc_disable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Completed control register writes, one per byte lane.
   sequence hi_wr_s;
      wb_ack_o && wb_we_i && wb_adr_i == 16'h70C8 && wb_sel_i[1];
   endsequence
   sequence lo_wr_s;
      wb_ack_o && wb_we_i && wb_adr_i == 16'h70C8 && wb_sel_i[0];
   endsequence
   pwdn_write_a: assert property (hi_wr_s |=> module_power_down_o == $past(wb_dat_i[15]))
      else $error("power down wrong");
   sesend_write_a: assert property (hi_wr_s |=> session_end_comparator_enable_o == $past(wb_dat_i[14]))
      else $error("session end enable wrong");
   vbdet_write_a: assert property (hi_wr_s |=> vbus_detect_enable_o == $past(wb_dat_i[13]))
      else $error("vbus detect enable wrong");
   pll_override_a: assert property (pll_suspend_override_o [*2] |-> !pll_suspend_o)
      else $error("pll suspended");
   scr_rsvd_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h70C8 |->
      wb_dat_o[11:7] == 5'h00 && wb_dat_o[5:4] == 2'h0) else $error("reserved bits nonzero");
   bias_write_a: assert property (lo_wr_s |=> osc_bias_disable_o == $past(wb_dat_i[3]))
      else $error("bias disable wrong");
   osc_write_a: assert property (lo_wr_s |=> osc_disable_o == $past(wb_dat_i[2]))
      else $error("oscillator disable wrong");
   sof_irq_a: assert property (core_evt_i.sof |-> ##[1:2] irq_o)
      else $error("no frame interrupt");
   pullup_follow_a: assert property ($rose(session_o) |-> ##2 fs_pullup_o)
      else $error("pull-up missing");
   reset_pulse_a: assert property (bus_reset_o |-> session_o ##1 !bus_reset_o)
      else $error("bus reset pulse wrong");
endmodule
bind usb_sys_config_fifo_alloc usb_sys_checker chk (.*);

// ---- usb_host_model.sv ----
/* Behavioural host at the far end of VBUS and the data lines.
   Assumes the bench commands supply and reset; pull-downs give SE0 when nobody pulls up. */
`timescale 1ns/1ps
module usb_host_model (
   input  wire logic clk_i,
   input  wire logic vbus_en_i,
   input  wire logic bus_reset_i,
   input  wire logic fs_pullup_i,
   input  wire logic dp_oe_i,
   input  wire logic dm_oe_i,
   input  wire logic dp_drv_i,
   input  wire logic dm_drv_i,
   output logic      vbus_valid_o,
   output logic      dp_o,
   output logic      dm_o
);
   logic rst_q;
   // Supply and reset signalling change just after an edge, like a real host seen through its cable.
   always_ff @(posedge clk_i) begin
      vbus_valid_o <= vbus_en_i;
      rst_q <= bus_reset_i;
   end
   // The device drive wins; otherwise reset forces SE0 and the pull-up lifts D+ over the pull-downs.
   assign dp_o = dp_oe_i ? dp_drv_i : (fs_pullup_i & !rst_q);
   assign dm_o = dm_oe_i ? dm_drv_i : 1'b0;
endmodule

// ---- tb.sv ----
/* Self-checking bench for the USB system block.
   Assumes the other files are compiled first. */
`timescale 1ns/1ps
`include "usb_sys_params.svh"
module tb
   import usb_sys_pkg::*;
;
   localparam logic [15:0] SCR_A = {`SCR_IDX, 2'h0};
   logic         clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic         session_end_i = 0, core_chirp_ok_i = 0, core_ram_we_i = 0, vbus_en = 0, bus_rst = 0;
   logic         vbus_valid_i, dp_i, dm_i, wb_ack_o, dp_o, dm_o, dp_oe_o, dm_oe_o, fs_pullup_o, irq_o;
   logic         session_o, high_speed_o, bus_reset_o, module_power_down_o, pll_suspend_o;
   logic         session_end_comparator_enable_o, vbus_detect_enable_o, pll_suspend_override_o;
   logic         osc_bias_disable_o, osc_disable_o;
   logic [15:0]  wb_adr_i = 0, core_ram_dat_i = 0, core_ram_dat_o;
   logic [3:0]   wb_sel_i = 4'hF;
   logic [31:0]  wb_dat_i = 0, wb_dat_o, q;
   logic [2:0]   core_ep_i = 0;
   logic [10:0]  core_ram_adr_i = 0;
   usb_line_t    core_line_i = '0, core_line_o;
   usb_evt_t     core_evt_i = '0;
   ep_fifo_cfg_t core_tx_cfg_o, core_rx_cfg_o;
   int           mismatches = 0, num_checks = 0, n;
   usb_sys_config_fifo_alloc uut (.*);
   usb_host_model host (.clk_i(clk_i), .vbus_en_i(vbus_en), .bus_reset_i(bus_rst), .fs_pullup_i(fs_pullup_o),
      .dp_oe_i(dp_oe_o), .dm_oe_i(dm_oe_o), .dp_drv_i(dp_o), .dm_drv_i(dm_o), .vbus_valid_o(vbus_valid_i),
      .dp_o(dp_i), .dm_o(dm_i));
   // Free-running 125 MHz clock.
   always #4 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One classic cycle; the slave sets the pace, the watchdog ends a hang.
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   task automatic test_reset();
      rdchk("control", SCR_A, {16'h0, `SCR_RESET});
      chk("pullup", {fs_pullup_o, session_o}, 0);
      rdchk("unmapped", 16'h0100, 0);
      $display("test reset done");
   endtask
   task automatic test_scr();
      wb(1'b1, SCR_A, 32'hFFFF, q);
      rdchk("control ones", SCR_A, {16'h0, `SCR_WR_MASK});
      chk("levels ones", {module_power_down_o, session_end_comparator_enable_o, vbus_detect_enable_o,
         pll_suspend_override_o, osc_bias_disable_o, osc_disable_o}, 6'h3F);
      wb(1'b1, SCR_A, 32'h0, q);
      rdchk("control zero", SCR_A, 0);
      chk("levels zero", {module_power_down_o, vbus_detect_enable_o, osc_disable_o}, 0);
      $display("test control register done");
   endtask
   // High lane, low lane, then the reserved mode which must move nothing.
   task automatic test_lanes();
      for (int m = 1; m < 4; m++) begin
         wb(1'b1, SCR_A, 32'h40 | m, q);
         wb(1'b1, 16'h0018, m == 2 ? 32'h0055 : 32'h07FF, q);
      end
      wb(1'b1, SCR_A, 32'h40, q);
      rdchk("lane merge", 16'h0018, 32'h0755);
      $display("test byte lanes done");
   endtask
   task automatic test_fifo();
      wb(1'b1, 16'h0004, 0, q);
      wb(1'b1, 16'h0008, 32'hFFFFFF, q);
      rdchk("ep0 cfg", 16'h0008, {8'h0, 1'b0, `EP0_MAXPKT, `EP0_START});
      wb(1'b1, 16'h0004, 4, q);
      wb(1'b1, 16'h0008, 32'hA00100, q);
      wb(1'b1, 16'h0004, 5, q);
      wb(1'b1, 16'h0008, 32'h0, q);
      wb(1'b1, 16'h0004, 4, q);
      rdchk("ep4 cfg", 16'h0008, 32'hA00100);
      wb(1'b1, 16'h0018, 32'h7FF, q);
      wb(1'b1, 16'h001C, 32'h1234, q);
      core_ep_i <= 4;
      core_ram_adr_i <= 11'h7FF;
      repeat (2) @(posedge clk_i);
      chk("engine cfg", core_tx_cfg_o, 32'hA00100);
      chk("top word", core_ram_dat_o, 32'h1234);
      core_ram_adr_i <= 11'h005;
      core_ram_we_i <= 1;
      core_ram_dat_i <= 16'hBEEF;
      @(posedge clk_i);
      core_ram_we_i <= 0;
      wb(1'b1, 16'h0018, 32'h5, q);
      rdchk("engine word", 16'h001C, 32'hBEEF);
      $display("test fifo done");
   endtask
   task automatic test_session();
      wb(1'b1, SCR_A, 32'h2040, q);
      vbus_en <= 1;
      wb(1'b1, 16'h0000, 32'h2, q);
      repeat (8) @(posedge clk_i);
      chk("no attach", session_o, 0);
      wb(1'b1, 16'h0000, 32'h3, q);
      for (n = 0; n < 20 && session_o !== 1'b1; n++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk("session", {session_o, fs_pullup_o}, 2'h3);
      chk("line normal", {core_line_o.dp, core_line_o.dm}, 2'h2);
      wb(1'b1, SCR_A, 32'h2000, q);
      repeat (3) @(posedge clk_i);
      chk("line swapped", {core_line_o.dp, core_line_o.dm}, 2'h1);
      wb(1'b1, SCR_A, 32'h2040, q);
      bus_rst <= 1;
      for (n = 0; n < 400 && bus_reset_o !== 1'b1; n++) @(posedge clk_i);
      bus_rst <= 0;
      chk("reset span", n >= `BUS_RESET_CYC && n < 400, 1);
      chk("full speed", high_speed_o, 0);
      wb(1'b0, 16'h0010, 0, q);
      chk("active", q & 32'hC, 32'h8);
      wb(1'b0, 16'h0014, 0, q);
      chk("reset cause", q[11], 1);
      $display("test session done");
   endtask
   task automatic test_irq();
      wb(1'b0, 16'h0014, 0, q);
      core_evt_i <= '1;
      @(posedge clk_i);
      core_evt_i <= '0;
      repeat (2) @(posedge clk_i);
      chk("irq raised", irq_o, 1);
      rdchk("causes", 16'h0014, 32'h47FF);
      chk("irq cleared", irq_o, 0);
      $display("test interrupts done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      test_reset();
      test_scr();
      test_lanes();
      test_fifo();
      test_session();
      test_irq();
      give_verdict();
   end
   // Watchdog; the tests need about five hundred cycles.
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
endmodule
